// File: rtl/via_adapter.sv
/*
 * Request processor of a virtual I2C adapter with APB register access.
 * Assumes a 10 MHz pclk, APB master outside and pads resolving the open-drain bus.
 */
`timescale 1ns/1ps
// Operation
// RULE1: Zero-length feature is always offered; driver without it is refused.
// RULE2: Driver accepts that feature or abandons negotiation.
// RULE3: Request is address word, padding, flags word, optional buffer, status byte.
// RULE4: Seven-bit address sits in bits 7..1, other bits zero.
// RULE5: Ten-bit address: low byte in 15..8, marker 11110, A9 A8 in 2..1.
// RULE6: Driver sets group-continue on all but the last request of a group.
// RULE7: Failure under group-continue fails the next request unexecuted.
// RULE8: Flags bit 1 set means read, clear means write.
// RULE9: Driver writes zero to all other flag bits.
// RULE10: Device never alters address word or reserved flag bits.
// RULE11: Zero-length request carries no buffer.
// RULE12: Status byte is 0 on success, 1 on failure.
// RULE13: Read fills the buffer with one segment of the requested length.
// RULE14: Write sends the buffer and leaves it unchanged.
// RULE15: Requests are posted and processed strictly in order.
// RULE16: First failed request is marked failed; rest of group may be too.
// RULE17: Driver treats failed request and rest of group as failed.
// RULE18: Driver fills address and flags before posting.
// RULE19: Read flag matches a device-writable buffer.
// RULE20: Write-then-read is a write request grouped with a read request.
// RULE21: A group runs as one transaction with repeated starts, stop at end.
module via_adapter
	import via_pkg::*;
(
	input  logic        pclk,
	input  logic        presetn,
	input  logic        ce,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic        scl_sense,
	output logic        scl_level,
	output logic        scl_oe,
	input  logic        sda_sense,
	output logic        sda_level,
	output logic        sda_oe
);
	typedef enum logic [3:0] {S_IDLE, S_START, S_A1, S_A2, S_RS, S_A3, S_DATA, S_END, S_DONE} via_state_type;

	via_state_type                  state_r;
	logic [15:0]                    addr_r;
	logic [31:0]                    flags_r;
	logic [IDX_W-1:0]               len_r;
	logic [IDX_W-1:0]               idx_r;
	logic [BUF_DEPTH-1:0][7:0]      buf_r;
	logic [7:0]                     stat_r;
	logic                           dfeat_r;
	logic                           drv_ok_r;
	logic                           reject_r;
	logic                           done_r;
	logic                           fail_r;
	logic                           fail_pend_r;
	logic                           own_r;
	logic                           wait_r;
	logic                           cmd_go_r;
	via_req_type                    cmd_r;
	via_req_type                    cmd_nxt;
	logic                           eng_done;
	via_res_type                    eng_res;
	logic                           busy;
	logic                           ten;
	logic                           rd;
	logic                           setup_acc;
	logic                           commit;
	logic                           wr_ok;
	logic                           go;
	logic                           cap;
	logic [31:0]                    rdata_nxt;
	logic                           err_nxt;

	// Buffer window hit test and word index inside it
	function automatic logic buf_hit(input logic [11:0] a);
		return (a >= OFS_BUF) && (a < OFS_BUF_END);
	endfunction

	function automatic logic [BUF_AW-1:0] buf_idx(input logic [11:0] a);
		return BUF_AW'((a - OFS_BUF) >> WORD_SHIFT);
	endfunction

	// Request decode
	assign busy      = (state_r != S_IDLE);
	assign ten       = via_ten_bit(addr_r);
	assign rd        = flags_r[FLG_RD];
	assign setup_acc = psel && penable && !pready;
	assign commit    = psel && penable && pready;
	assign wr_ok     = commit && pwrite && !pslverr;
	assign go        = wr_ok && (paddr == OFS_SUBMIT); // RULE15
	assign cap       = (state_r == S_DATA) && wait_r && eng_done && rd;

	// Read data and refusal decode
	always_comb
	begin
		rdata_nxt = '0;
		err_nxt   = 1'b0;
		unique case (paddr)
			OFS_FEAT:   rdata_nxt = DEV_FEATURES; // RULE1
			OFS_DFEAT:  rdata_nxt[FEAT_ZLEN] = dfeat_r;
			OFS_CTRL:   rdata_nxt[CTRL_DRV_OK] = drv_ok_r;
			OFS_ADDR:   rdata_nxt[15:0] = addr_r;
			OFS_FLAGS:  rdata_nxt = flags_r;
			OFS_LEN:    rdata_nxt[IDX_W-1:0] = len_r;
			OFS_SUBMIT: err_nxt = pwrite && (busy || !drv_ok_r); // RULE15
			OFS_STAT:
			begin
				rdata_nxt[7:0]         = stat_r;
				rdata_nxt[ST_DONE]     = done_r;
				rdata_nxt[ST_BUSY]     = busy;
				rdata_nxt[ST_REJECT]   = reject_r;
				rdata_nxt[ST_FAILPEND] = fail_pend_r;
				rdata_nxt[ST_HELD]     = own_r;
			end
			default:
			begin
				if (buf_hit(paddr))
					rdata_nxt[7:0] = buf_r[buf_idx(paddr)];
				else
					err_nxt = 1'b1;
			end
		endcase
		if (pwrite && busy && (paddr == OFS_ADDR || paddr == OFS_FLAGS || paddr == OFS_LEN || buf_hit(paddr)))
			err_nxt = 1'b1; // RULE10
		if (pwrite && paddr == OFS_LEN && pwdata > 32'(BUF_DEPTH))
			err_nxt = 1'b1;
	end

	// APB answer: one wait state, data and error loaded with pready
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else if (ce)
		begin
			pready  <= setup_acc;
			pslverr <= setup_acc && err_nxt;
			if (setup_acc && !pwrite)
				prdata <= rdata_nxt;
		end

	// Negotiation and request header registers
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			dfeat_r  <= 1'b0;
			drv_ok_r <= 1'b0;
			reject_r <= 1'b0;
			addr_r   <= '0;
			flags_r  <= '0;
			len_r    <= '0;
		end
		else if (ce && wr_ok)
		begin
			unique case (paddr)
				OFS_DFEAT: dfeat_r <= pwdata[FEAT_ZLEN] & DEV_FEATURES[FEAT_ZLEN];
				OFS_CTRL:
				begin
					drv_ok_r <= pwdata[CTRL_DRV_OK] && dfeat_r; // RULE1
					reject_r <= pwdata[CTRL_DRV_OK] && !dfeat_r; // RULE1
				end
				OFS_ADDR:  addr_r  <= pwdata[15:0]; // RULE3
				OFS_FLAGS: flags_r <= pwdata;
				OFS_LEN:   len_r   <= pwdata[IDX_W-1:0];
				default:   ;
			endcase
		end

	// Data buffer: software fills it, reads from the target land in it
	for (genvar i = 0; i < BUF_DEPTH; i++)
	begin : g_buf
		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
				buf_r[i] <= '0;
			else if (ce)
			begin
				if (cap && idx_r == IDX_W'(i))
					buf_r[i] <= eng_res.data; // RULE13
				else if (wr_ok && buf_hit(paddr) && buf_idx(paddr) == BUF_AW'(i))
					buf_r[i] <= pwdata[7:0];
			end
	end

	// Command for the bit engine in each state
	always_comb
	begin
		cmd_nxt      = '0;
		cmd_nxt.op   = CMD_WRITE;
		unique case (state_r)
			S_START, S_RS: cmd_nxt.op = CMD_START; // RULE21
			S_A1:          cmd_nxt.data = {addr_r[A_LO_MSB:A_LO_LSB], ten ? 1'b0 : rd}; // RULE4 RULE5 RULE8
			S_A2:          cmd_nxt.data = addr_r[A_HI_MSB:A_HI_LSB]; // RULE5
			S_A3:          cmd_nxt.data = {addr_r[A_LO_MSB:A_LO_LSB], 1'b1}; // RULE5
			S_DATA:
			begin
				cmd_nxt.op   = rd ? CMD_READ : CMD_WRITE; // RULE8
				cmd_nxt.data = buf_r[idx_r[BUF_AW-1:0]]; // RULE14
				cmd_nxt.nack = (idx_r + IDX_ONE == len_r);
			end
			S_END:         cmd_nxt.op = CMD_STOP;
			default:       ;
		endcase
	end

	// Request sequencer
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state_r     <= S_IDLE;
			idx_r       <= '0;
			stat_r      <= MSG_OK;
			done_r      <= 1'b0;
			fail_r      <= 1'b0;
			fail_pend_r <= 1'b0;
			own_r       <= 1'b0;
			wait_r      <= 1'b0;
			cmd_go_r    <= 1'b0;
			cmd_r       <= '0;
		end
		else if (ce)
		begin
			cmd_go_r <= 1'b0;
			unique case (state_r)
				S_IDLE:
				begin
					if (go)
					begin
						idx_r  <= '0;
						fail_r <= 1'b0;
						if (fail_pend_r)
						begin
							stat_r      <= MSG_ERR; // RULE7
							done_r      <= 1'b1;
							fail_pend_r <= flags_r[FLG_GRP]; // RULE16
						end
						else
						begin
							done_r  <= 1'b0;
							fail_r  <= !via_addr_ok(addr_r); // RULE4 RULE5
							state_r <= via_addr_ok(addr_r) ? S_START : S_END;
						end
					end
				end
				S_DONE:
				begin
					stat_r      <= fail_r ? MSG_ERR : MSG_OK; // RULE12 RULE16
					done_r      <= 1'b1;
					fail_pend_r <= fail_r && flags_r[FLG_GRP]; // RULE7
					state_r     <= S_IDLE;
				end
				default:
				begin
					if ((state_r == S_DATA && idx_r == len_r) ||
						(state_r == S_END && !(own_r && (fail_r || !flags_r[FLG_GRP]))))
						state_r <= (state_r == S_DATA) ? S_END : S_DONE; // RULE11 RULE20 RULE21
					else if (!wait_r)
					begin
						cmd_go_r <= 1'b1;
						cmd_r    <= cmd_nxt;
						wait_r   <= 1'b1;
					end
					else if (eng_done)
					begin
						wait_r <= 1'b0;
						unique case (state_r)
							S_START:
							begin
								own_r   <= 1'b1;
								state_r <= S_A1;
							end
							S_A1, S_A2, S_A3:
							begin
								if (eng_res.nack)
								begin
									fail_r  <= 1'b1;
									state_r <= S_END;
								end
								else if (state_r == S_A1 && ten)
									state_r <= S_A2;
								else if (state_r == S_A2 && rd)
									state_r <= S_RS;
								else
									state_r <= S_DATA;
							end
							S_RS: state_r <= S_A3;
							S_DATA:
							begin
								idx_r <= idx_r + IDX_ONE; // RULE13
								if (!rd && eng_res.nack)
								begin
									fail_r  <= 1'b1;
									state_r <= S_END;
								end
							end
							default:
							begin
								own_r   <= 1'b0; // RULE21
								state_r <= S_DONE;
							end
						endcase
					end
				end
			endcase
		end

	// Bit engine driving the bus pins
	via_i2c_eng u_eng (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.req_go    (cmd_go_r),
		.req       (cmd_r),
		.done      (eng_done),
		.res       (eng_res),
		.scl_sense (scl_sense),
		.scl_level (scl_level),
		.scl_oe    (scl_oe),
		.sda_sense (sda_sense),
		.sda_level (sda_level),
		.sda_oe    (sda_oe)
	);

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [IDX_W-1:0] rd_cnt;

	// Count bytes captured from the target per request
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rd_cnt <= '0;
		else if (ce)
		begin
			if (go)
				rd_cnt <= '0;
			else if (cap)
				rd_cnt <= rd_cnt + IDX_ONE;
		end

	property p_reject;
		ce && wr_ok && paddr == OFS_CTRL && pwdata[CTRL_DRV_OK] && !dfeat_r |=> reject_r && !drv_ok_r;
	endproperty
	a_reject: assert property (p_reject) else $error("driver without feature not refused"); // RULE1

	property p_feat_read;
		ce && setup_acc && !pwrite && paddr == OFS_FEAT |=> prdata[FEAT_ZLEN] && pready;
	endproperty
	a_feat_read: assert property (p_feat_read) else $error("zero-length feature not offered"); // RULE1

	property p_addr_byte;
		cmd_go_r && state_r == S_A1 |-> cmd_r.op == CMD_WRITE &&
			cmd_r.data[7:1] == addr_r[A_LO_MSB:A_LO_LSB] && cmd_r.data[0] == (!ten && rd);
	endproperty
	a_addr_byte: assert property (p_addr_byte) else $error("address byte malformed"); // RULE4

	property p_ten_hi;
		cmd_go_r && state_r == S_A2 |-> ten && cmd_r.data == addr_r[A_HI_MSB:A_HI_LSB];
	endproperty
	a_ten_hi: assert property (p_ten_hi) else $error("ten-bit second byte wrong"); // RULE5

	property p_skip;
		ce && go && fail_pend_r |=> state_r == S_IDLE && done_r && stat_r == MSG_ERR;
	endproperty
	a_skip: assert property (p_skip) else $error("grouped request ran after failure"); // RULE7

	property p_hdr_stable;
		ce && busy |=> $stable(addr_r) && $stable(flags_r);
	endproperty
	a_hdr_stable: assert property (p_hdr_stable) else $error("header changed while busy"); // RULE10

	property p_status;
		done_r |-> (stat_r == MSG_OK || stat_r == MSG_ERR);
	endproperty
	a_status: assert property (p_status) else $error("status byte out of range"); // RULE12

	property p_rd_len;
		state_r == S_DONE && rd && !fail_r |-> rd_cnt == len_r;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read length mismatch"); // RULE13

	property p_wbuf;
		ce && busy && !rd |=> $stable(buf_r);
	endproperty
	a_wbuf: assert property (p_wbuf) else $error("write buffer modified"); // RULE14

	property p_order;
		ce && setup_acc && pwrite && paddr == OFS_SUBMIT && busy |=> pready && pslverr;
	endproperty
	a_order: assert property (p_order) else $error("submit accepted while busy"); // RULE15

	property p_fail_mark;
		ce && state_r == S_DONE && fail_r |=> stat_r == MSG_ERR && state_r == S_IDLE;
	endproperty
	a_fail_mark: assert property (p_fail_mark) else $error("failed request not marked"); // RULE16

	property p_stop_last;
		cmd_go_r && cmd_r.op == CMD_STOP |-> fail_r || !flags_r[FLG_GRP];
	endproperty
	a_stop_last: assert property (p_stop_last) else $error("stop inside a group"); // RULE21

	c_quick: cover property (state_r == S_DONE && len_r == '0 && !fail_r);
	c_group: cover property (state_r == S_DONE && !fail_r && flags_r[FLG_GRP] && own_r);
	c_skip:  cover property (go && fail_pend_r);
	c_ten:   cover property (cmd_go_r && state_r == S_A3);
endmodule

// File: shared/via_pkg.sv
/*
 * Shared constants and types of the virtual I2C adapter request processor.
 * Assumes one 10 MHz clock, APB register access and an open-drain I2C bus.
 */
package via_pkg;
	// Clock and I2C timing (standard mode bit time, split in four quarters)
	localparam int          CLK_NS     = 100;
	localparam int          I2C_BIT_NS = 10000;
	localparam int          QTR_CYC    = (I2C_BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
	localparam int          QTR_W      = 5;
	localparam logic [4:0]  QTR_LAST   = 5'(QTR_CYC - 1);
	localparam logic [4:0]  QTR_ONE    = 5'h01;

	// Engine bit framing: eight data bits plus acknowledge
	localparam int          SH_W       = 9;
	localparam logic [3:0]  BIT_LAST   = 4'h8;
	localparam logic [3:0]  BIT_ONE    = 4'h1;
	localparam logic [7:0]  BYTE_ONES  = 8'hff;
	localparam logic [1:0]  PH_DRIVE   = 2'h0;
	localparam logic [1:0]  PH_RISE    = 2'h1;
	localparam logic [1:0]  PH_SAMPLE  = 2'h2;
	localparam logic [1:0]  PH_FALL    = 2'h3;
	localparam logic [1:0]  PH_ONE     = 2'h1;

	// Data buffer
	localparam int          BUF_DEPTH  = 8;
	localparam int          BUF_AW     = 3;
	localparam int          IDX_W      = 4;
	localparam logic [3:0]  IDX_ONE    = 4'h1;

	// Register map (byte addresses)
	localparam logic [11:0] OFS_FEAT   = 12'h000;
	localparam logic [11:0] OFS_DFEAT  = 12'h004;
	localparam logic [11:0] OFS_CTRL   = 12'h008;
	localparam logic [11:0] OFS_ADDR   = 12'h00c;
	localparam logic [11:0] OFS_FLAGS  = 12'h010;
	localparam logic [11:0] OFS_LEN    = 12'h014;
	localparam logic [11:0] OFS_SUBMIT = 12'h018;
	localparam logic [11:0] OFS_STAT   = 12'h01c;
	localparam logic [11:0] OFS_BUF    = 12'h040;
	localparam logic [11:0] OFS_BUF_END = 12'h060;
	localparam int          WORD_SHIFT = 2;

	// Feature, flag, control and status fields
	localparam logic [31:0] DEV_FEATURES = 32'h0000_0001;
	localparam int          FEAT_ZLEN  = 0;
	localparam int          CTRL_DRV_OK = 0;
	localparam int          FLG_GRP    = 0;
	localparam int          FLG_RD     = 1;
	localparam int          ST_DONE    = 8;
	localparam int          ST_BUSY    = 9;
	localparam int          ST_REJECT  = 10;
	localparam int          ST_FAILPEND = 11;
	localparam int          ST_HELD    = 12;
	localparam logic [7:0]  MSG_OK     = 8'h00;
	localparam logic [7:0]  MSG_ERR    = 8'h01;

	// Target address word fields
	localparam int          A_LO_MSB   = 7;
	localparam int          A_LO_LSB   = 1;
	localparam int          A_HI_MSB   = 15;
	localparam int          A_HI_LSB   = 8;
	localparam int          A_ZERO_BIT = 0;
	localparam int          TEN_MSB    = 7;
	localparam int          TEN_LSB    = 3;
	localparam logic [4:0]  TEN_MARK   = 5'h1e;
	localparam logic [7:0]  HI_ZERO    = 8'h00;

	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} via_cmd_type;

	typedef struct packed {
		via_cmd_type op;
		logic [7:0]  data;
		logic        nack;
	} via_req_type;

	typedef struct packed {
		logic [7:0] data;
		logic       nack;
	} via_res_type;

	// Ten-bit target marker in the low address byte
	function automatic logic via_ten_bit(input logic [15:0] a);
		return a[TEN_MSB:TEN_LSB] == TEN_MARK;
	endfunction

	// Address word well formed for either addressing mode
	function automatic logic via_addr_ok(input logic [15:0] a);
		return (a[A_ZERO_BIT] == 1'b0) && (via_ten_bit(a) || a[A_HI_MSB:A_HI_LSB] == HI_ZERO);
	endfunction
endpackage

// File: rtl/via_i2c_eng.sv
/*
 * I2C bit engine: runs one start, stop, byte write or byte read per command.
 * Assumes bus inputs synchronous to pclk and open-drain pads outside.
 */
`timescale 1ns/1ps
module via_i2c_eng
	import via_pkg::*;
(
	input  logic        pclk,
	input  logic        presetn,
	input  logic        ce,
	input  logic        req_go,
	input  via_req_type req,
	output logic        done,
	output via_res_type res,
	input  logic        scl_sense,
	output logic        scl_level,
	output logic        scl_oe,
	input  logic        sda_sense,
	output logic        sda_level,
	output logic        sda_oe
);
	typedef enum logic [1:0] {E_IDLE, E_START, E_STOP, E_BIT} via_eng_type;

	via_eng_type        state_r;
	logic [QTR_W-1:0]   qcnt_r;
	logic [1:0]         phase_r;
	logic [3:0]         bit_r;
	logic [SH_W-1:0]    tx_r;
	logic [SH_W-1:0]    rx_r;
	logic               stall;
	logic               tick;

	// Target holds clock low while released: wait
	assign stall = !scl_oe && !scl_sense;
	assign tick  = (qcnt_r == QTR_LAST);

	// Open drain: the driven level is always low
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			scl_level <= 1'b0;
			sda_level <= 1'b0;
		end

	// Quarter-bit sequencer
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			state_r <= E_IDLE;
			qcnt_r  <= '0;
			phase_r <= PH_DRIVE;
			bit_r   <= '0;
			tx_r    <= '0;
			rx_r    <= '0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
			done    <= 1'b0;
			res     <= '0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (state_r == E_IDLE)
			begin
				qcnt_r  <= '0;
				phase_r <= PH_DRIVE;
				bit_r   <= '0;
				if (req_go)
				begin
					unique case (req.op)
						CMD_START:
						begin
							state_r <= E_START;
							sda_oe  <= 1'b0;
						end
						CMD_STOP:
						begin
							state_r <= E_STOP;
							sda_oe  <= 1'b1;
						end
						CMD_WRITE:
						begin
							state_r <= E_BIT;
							tx_r    <= {req.data, 1'b1};
							sda_oe  <= !req.data[SH_W-2];
						end
						CMD_READ:
						begin
							state_r <= E_BIT;
							tx_r    <= {BYTE_ONES, req.nack};
							sda_oe  <= 1'b0;
						end
					endcase
				end
			end
			else if (!stall)
			begin
				if (!tick)
					qcnt_r <= qcnt_r + QTR_ONE;
				else
				begin
					qcnt_r  <= '0;
					phase_r <= phase_r + PH_ONE;
					unique case (phase_r)
						PH_DRIVE: scl_oe <= 1'b0;
						PH_RISE:
						begin
							if (state_r == E_START)
								sda_oe <= 1'b1;
							if (state_r == E_BIT)
								rx_r <= {rx_r[SH_W-2:0], sda_sense};
						end
						PH_SAMPLE:
						begin
							if (state_r == E_STOP)
								sda_oe <= 1'b0;
							else
								scl_oe <= 1'b1;
						end
						PH_FALL:
						begin
							if (state_r == E_BIT && bit_r != BIT_LAST)
							begin
								bit_r  <= bit_r + BIT_ONE;
								tx_r   <= {tx_r[SH_W-2:0], 1'b0};
								sda_oe <= !tx_r[SH_W-2];
							end
							else
							begin
								state_r <= E_IDLE;
								done    <= 1'b1;
								res     <= {rx_r[SH_W-1:1], rx_r[0]};
							end
						end
					endcase
				end
			end
		end
endmodule

// File: bench/via_tgt.sv
/*
 * I2C target model: seven- or ten-bit address, acks writes, serves a fixed read byte.
 * Assumes open-drain wires resolved by the bench with pull-ups on both lines.
 */
`timescale 1ns/1ps
module via_tgt #(
	parameter logic [6:0] ADR = 7'h50,
	parameter logic [9:0] TAD = 10'h15a,
	parameter logic [7:0] RDB = 8'ha5
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_oe
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rx = 8'h00;
	logic [7:0] ab = 8'h00;
	logic       hit = 1'b0;
	logic       rd = 1'b0;
	logic       first = 1'b0;
	logic       act = 1'b0;
	logic       ten = 1'b0;
	logic       mack = 1'b0;
	int         n = 0;
	int         nst = 0;
	int         nsp = 0;
	initial sda_oe = 1'b0;
	// Start or repeated start opens an address phase
	always @(negedge sda)
	begin
		if (scl)
		begin
			act = 1'b1;
			first = 1'b1;
			n = 0;
			nst++;
		end
	end
	// Stop closes the frame
	always @(posedge sda)
	begin
		if (scl && act)
		begin
			act = 1'b0;
			nsp++;
		end
	end
	// Bits are taken on the rising clock
	always @(posedge scl)
	begin
		if (act && n < 8)
		begin
			sh = {sh[6:0], sda};
			n++;
		end
		else if (act && n == 9)
			mack = !sda; // Master acknowledge of a read byte
	end
	// Acknowledge and read data change only while the clock is low
	always @(negedge scl)
	begin
		if (act && n == 8)
		begin
			if (first)
			begin
				ab = sh;
				ten = sh[7:1] == {5'h1e, TAD[9:8]} && !sh[0];
				hit = sh[7:1] == ADR || sh[7:1] == {5'h1e, TAD[9:8]};
				rd = sh[0];
			end
			else if (ten)
			begin
				ten = 1'b0;
				hit = sh == TAD[7:0];
			end
			else if (!rd)
				rx = sh;
			sda_oe = hit && (first || !rd);
			first = 1'b0;
			n = 9;
		end
		else if (act && n == 9)
		begin
			n = 0;
			sda_oe = hit && rd && mack && !RDB[7];
		end
		else if (act && hit && rd && mack && !first && n < 8)
			sda_oe = !RDB[7 - n];
	end
endmodule

// File: bench/via_adapter_tb.sv
/*
 * Testbench of the adapter: APB driver tasks, target model, scripted requests.
 * Assumes one APB wait state from the adapter and pull-ups on both bus lines.
 */
`timescale 1ns/1ps
module via_adapter_tb import via_pkg::*;;
	localparam logic [15:0] A7 = 16'h00a0;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        scl_level, scl_oe, sda_level, sda_oe, t_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	int          errors, comparisons, s;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe || t_oe);
	// Free-running bus clock
	always #50 pclk = !pclk;
	via_adapter i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_sense(scl), .scl_level(scl_level), .scl_oe(scl_oe),
		.sda_sense(sda), .sda_level(sda_level), .sda_oe(sda_oe));
	via_tgt i_tgt (.scl(scl), .sda(sda), .sda_oe(t_oe));
	task automatic final_report();
		$display("counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; answer lands in rv and er
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (k == 20)
		begin
			errors++;
			final_report();
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rv);
	endtask
	// Post one request without waiting for it
	task automatic post(input logic [15:0] a, input logic [1:0] f, input logic [31:0] len);
		apb(1'b1, OFS_ADDR, {16'h0000, a});
		apb(1'b1, OFS_FLAGS, {30'h0000_0000, f});
		apb(1'b1, OFS_LEN, len);
		apb(1'b1, OFS_SUBMIT, 32'h0000_0000);
	endtask
	// Wait for completion and check the status byte
	task automatic fin(input logic [7:0] st);
		int k;
		for (k = 0; k < 3000; k++)
		begin
			apb(1'b0, OFS_STAT, 32'h0000_0000);
			if (rv[ST_DONE] === 1'b1)
				break;
		end
		if (k == 3000)
		begin
			errors++;
			final_report();
		end
		chk("status", {24'h0000_00, st}, {24'h0000_00, rv[7:0]});
	endtask
	// Post one request and wait for its completion
	task automatic req(input logic [15:0] a, input logic [1:0] f, input logic [31:0] len, input logic [7:0] st);
		post(a, f, len);
		fin(st);
	endtask
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		comparisons = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc("features", OFS_FEAT, DEV_FEATURES);
		apb(1'b1, OFS_SUBMIT, 32'h0000_0000);
		chk("early submit", 32'h0000_0001, {31'h0, er});
		apb(1'b1, OFS_DFEAT, 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		rdc("reject", OFS_STAT, 32'h0000_0400);
		rdc("refused", OFS_CTRL, 32'h0000_0000);
		apb(1'b1, OFS_DFEAT, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		rdc("accepted", OFS_CTRL, 32'h0000_0001);
		apb(1'b0, 12'h0fc, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {31'h0, er});
		chk("pad levels", 32'h0000_0000, {30'h0, scl_level, sda_level});
		$display("test setup done");
		apb(1'b1, OFS_BUF, 32'h0000_003c);
		req(A7, 2'b00, 32'h0000_0001, MSG_OK);
		chk("addr byte", 32'h0000_00a0, {24'h0, i_tgt.ab});
		chk("sent byte", 32'h0000_003c, {24'h0, i_tgt.rx});
		rdc("write buf", OFS_BUF, 32'h0000_003c);
		rdc("addr kept", OFS_ADDR, 32'h0000_00a0);
		req(A7, 2'b00, 32'h0000_0000, MSG_OK);
		$display("test write done");
		s = i_tgt.nsp;
		req(A7, 2'b01, 32'h0000_0001, MSG_OK);
		req(A7, 2'b10, 32'h0000_0002, MSG_OK);
		chk("one stop", s + 1, i_tgt.nsp);
		rdc("read buf0", OFS_BUF, 32'h0000_00a5);
		rdc("read buf1", OFS_BUF + 12'h004, 32'h0000_00a5);
		$display("test group done");
		apb(1'b1, OFS_BUF, 32'h0000_0069);
		req(16'h5af2, 2'b00, 32'h0000_0001, MSG_OK);
		chk("ten first", 32'h0000_00f2, {24'h0, i_tgt.ab});
		chk("ten data", 32'h0000_0069, {24'h0, i_tgt.rx});
		req(16'h5af2, 2'b10, 32'h0000_0001, MSG_OK);
		chk("ten read addr", 32'h0000_00f3, {24'h0, i_tgt.ab});
		rdc("ten read buf", OFS_BUF, 32'h0000_00a5);
		$display("test ten-bit done");
		req(16'h34f6, 2'b01, 32'h0000_0001, MSG_ERR);
		chk("ten bit", 32'h0000_00f6, {24'h0, i_tgt.ab});
		s = i_tgt.nst;
		req(A7, 2'b00, 32'h0000_0001, MSG_ERR);
		req(16'h00a1, 2'b00, 32'h0000_0001, MSG_ERR);
		chk("no start", s, i_tgt.nst);
		post(A7, 2'b00, 32'h0000_0001);
		apb(1'b1, OFS_SUBMIT, 32'h0000_0000);
		chk("busy submit", 32'h0000_0001, {31'h0, er});
		apb(1'b1, OFS_ADDR, 32'h0000_0000);
		chk("busy addr", 32'h0000_0001, {31'h0, er});
		fin(MSG_OK);
		rdc("addr held", OFS_ADDR, 32'h0000_00a0);
		$display("test failure done");
		final_report();
	end
endmodule
